/* hdl/rec_host_pkg.sv */
// Constants for the record transfer host controller.
// Assumes a device host port with three word registers picked by a two-bit address.
`default_nettype none
package rec_host_pkg;
   // ************************************************************
   // Software register map (byte addresses).
   // ************************************************************
   localparam logic [7:0] SW_CONTROL = 8'h00;
   localparam logic [7:0] SW_STATUS = 8'h04;
   localparam logic [7:0] SW_RESPONSE = 8'h08;
   localparam logic [7:0] SW_FRAMES = 8'h0c;
   localparam logic [7:0] SW_INDEX = 8'h10;
   localparam logic [7:0] SW_DATA = 8'h14;
   localparam int CTL_START = 0;
   localparam int CTL_LINEAR = 1;
   localparam int CTL_STOP = 2;
   localparam int STS_BUSY = 0;
   localparam int STS_RECORDING = 1;
   localparam int STS_ERROR = 2;
   localparam int STS_LINEAR = 3;
   localparam int STS_STOP_PEND = 4;
   // ************************************************************
   // Device host port map.
   // ************************************************************
   localparam logic [1:0] DEV_SW_REG = 2'h0;
   localparam logic [1:0] DEV_HW_REG = 2'h1;
   localparam logic [1:0] DEV_RX_BUF = 2'h2;
   localparam int HWS_COMMAND_ACCEPTING = 0;
   localparam int HWS_RESPONSE_PENDING = 1;
   localparam int HWS_RX_FRAME_AVAIL = 2;
   // ************************************************************
   // Command and control words.
   // ************************************************************
   localparam logic [15:0] CMD_POLL_SYNC = 16'h5102;
   localparam logic [15:0] CMD_REC_COMPRESSED = 16'h1c03;
   localparam logic [15:0] CMD_REC_LINEAR = 16'h1e83;
   localparam logic [15:0] CMD_STOP_RECORD = 16'h5120;
   localparam logic [15:0] HWC_IRQ_RX = 16'h0401;
   localparam logic [15:0] HWC_DMA_BURST = 16'h0050;
   localparam logic [15:0] HWC_OFF = 16'h0000;
   // ************************************************************
   // Frame geometry.
   // ************************************************************
   localparam logic [4:0] CMP_BURST_WORDS = 5'd10;
   localparam logic [4:0] LIN_BURST_WORDS = 5'd16;
   localparam logic [7:0] CMP_FRAME_WORDS = 8'd10;
   localparam logic [7:0] LIN_FRAME_WORDS = 8'd240;
   localparam int FRAME_MEM_DEPTH = 256;
   typedef enum logic [13:0] {
      ST_IDLE = 14'h0001,
      ST_POLL_CA = 14'h0002,
      ST_CHK_CA = 14'h0004,
      ST_WR_CMD = 14'h0008,
      ST_POLL_RP = 14'h0010,
      ST_CHK_RP = 14'h0020,
      ST_RD_RESP = 14'h0040,
      ST_GET_RESP = 14'h0080,
      ST_WR_HWC = 14'h0100,
      ST_WAIT_FRM = 14'h0200,
      ST_RD_BUF = 14'h0400,
      ST_GET_BUF = 14'h0800,
      ST_REARM = 14'h1000,
      ST_RESERVED = 14'h2000
   } state_e;
endpackage
`default_nettype wire

/* hdl/rec_host.sv */
// Host controller that starts, paces and stops record transfers of the speech co-processor.
// Assumes one-cycle device accesses: read data on the device bus in the cycle after a read strobe.
//
// Implementation choices: strobed register access and the register addresses.
`default_nettype none
// Function
// - Poll command_accepting in hardware status before each command write.
// - Wait for response_pending, then read the response from software status.
// - Select poll-synchronised record with 5102H and collect its acknowledgement.
// - Compressed record start 1C03H uses the receive buffer port, path 11.
// - Write 0401H to hardware control to interrupt on rx_frame_avail.
// - Read exactly 10 buffer words per interrupt at the 5.3 kbps rate.
// - To stop, write 0000H to hardware control, then stop command 5120H.
// - No receive buffer access after issuing the stop command.
// - Linear record start 1E83H, format 101, via the receive buffer port.
// - Write 0050H to hardware control for burst DMA receive requests.
// - Answer rx_dma_request with rx_dma_ack_n low and read 16 words.
// - Host frame buffer holds a whole number of frames.
// - Discard partial frames; stop only on a complete frame boundary.
// - Legacy protocol selects 8.5 kbps with 5130H, echoed by the device; this host never sends 5130H, it always selects with 5102H.
// - Low two command bits select transfer path; 11 means receive buffer.
module rec_host (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_sw_addr,
   input wire logic [31:0] i_sw_wdata,
   input wire logic i_sw_wr,
   input wire logic i_sw_rd,
   output logic [31:0] o_sw_rdata,
   output logic [1:0] o_dev_addr,
   output logic o_dev_cs_n,
   output logic o_dev_rd_n,
   output logic o_dev_wr_n,
   output logic [15:0] o_dev_data,
   output logic o_dev_data_oe,
   input wire logic [15:0] i_dev_data,
   input wire logic i_dev_irq,
   input wire logic i_rx_dma_request,
   output logic o_rx_dma_ack_n
);
   // ************************************************************
   // State and storage.
   // ************************************************************
   rec_host_pkg::state_e state;
   rec_host_pkg::state_e next_state;
   logic linear;
   logic started;
   logic stopping;
   logic stop_req;
   logic error;
   logic dma_ack;
   logic [15:0] response;
   logic [15:0] frames;
   logic [7:0] rd_index;
   logic [7:0] frame_word;
   logic [4:0] burst_word;
   logic [15:0] dout;
   logic [1:0] addr;
   logic [31:0] rdata;
   logic [15:0] frame_mem [0:rec_host_pkg::FRAME_MEM_DEPTH-1];

   // ************************************************************
   // Decoding.
   // ************************************************************
   wire sw_ctl_wr = i_sw_wr && (i_sw_addr == rec_host_pkg::SW_CONTROL);
   wire sw_idx_wr = i_sw_wr && (i_sw_addr == rec_host_pkg::SW_INDEX);
   wire sw_data_rd = i_sw_rd && (i_sw_addr == rec_host_pkg::SW_DATA);
   wire start_cmd = sw_ctl_wr && i_sw_wdata[rec_host_pkg::CTL_START];
   wire stop_cmd = sw_ctl_wr && i_sw_wdata[rec_host_pkg::CTL_STOP];
   wire idle = (state == rec_host_pkg::ST_IDLE);
   wire ca_seen = i_dev_data[rec_host_pkg::HWS_COMMAND_ACCEPTING];
   wire rp_seen = i_dev_data[rec_host_pkg::HWS_RESPONSE_PENDING];
   wire [15:0] rec_word = linear ? rec_host_pkg::CMD_REC_LINEAR : rec_host_pkg::CMD_REC_COMPRESSED;
   wire [15:0] cmd_word = stopping ? rec_host_pkg::CMD_STOP_RECORD :
                          (started ? rec_word : rec_host_pkg::CMD_POLL_SYNC);
   wire [15:0] hwc_on = linear ? rec_host_pkg::HWC_DMA_BURST : rec_host_pkg::HWC_IRQ_RX;
   // The write data are launched while the stop is still being taken in the wait state,
   // so that state must already pick the disabling word.
   wire hwc_off_now = stopping || (state == rec_host_pkg::ST_WAIT_FRM);
   wire [15:0] hwc_word = hwc_off_now ? rec_host_pkg::HWC_OFF : hwc_on;
   // Interrupt mode waits on the interrupt line; burst mode on the active-high DMA request.
   wire frame_ready = linear ? i_rx_dma_request : i_dev_irq;
   wire [4:0] burst_len = linear ? rec_host_pkg::LIN_BURST_WORDS : rec_host_pkg::CMP_BURST_WORDS;
   wire [7:0] frame_len = linear ? rec_host_pkg::LIN_FRAME_WORDS : rec_host_pkg::CMP_FRAME_WORDS;
   wire burst_last = (burst_word == burst_len - 5'd1);
   wire frame_last = (frame_word == frame_len - 8'd1);
   // Stopping is only taken between frames, so the frame buffer never ends on a partial frame.
   wire stop_now = stop_req && (frame_word == 8'd0);
   wire stop_take = (state == rec_host_pkg::ST_WAIT_FRM) && stop_now;
   wire ack_on = (state == rec_host_pkg::ST_WAIT_FRM) && !stop_now && frame_ready && linear;
   wire burst_done = (state == rec_host_pkg::ST_GET_BUF) && burst_last;
   wire frame_done = (state == rec_host_pkg::ST_GET_BUF) && frame_last;

   // ************************************************************
   // Sequencer.
   // ************************************************************
   // Every device read is a strobe state followed by a sampling state, because read data
   // stand on the device bus only in the cycle after the strobe.
   always_comb begin
      next_state = state;
      case (state)
         rec_host_pkg::ST_IDLE: begin
            if (start_cmd) begin
               next_state = rec_host_pkg::ST_POLL_CA;
            end
         end
         rec_host_pkg::ST_POLL_CA: begin
            next_state = rec_host_pkg::ST_CHK_CA;
         end
         rec_host_pkg::ST_CHK_CA: begin
            next_state = ca_seen ? rec_host_pkg::ST_WR_CMD : rec_host_pkg::ST_POLL_CA;
         end
         rec_host_pkg::ST_WR_CMD: begin
            next_state = rec_host_pkg::ST_POLL_RP;
         end
         rec_host_pkg::ST_POLL_RP: begin
            next_state = rec_host_pkg::ST_CHK_RP;
         end
         rec_host_pkg::ST_CHK_RP: begin
            // The record start answer comes only after the device has synchronised.
            next_state = rp_seen ? rec_host_pkg::ST_RD_RESP : rec_host_pkg::ST_POLL_RP;
         end
         rec_host_pkg::ST_RD_RESP: begin
            next_state = rec_host_pkg::ST_GET_RESP;
         end
         rec_host_pkg::ST_GET_RESP: begin
            if (stopping) begin
               next_state = rec_host_pkg::ST_IDLE;
            end else if (!started) begin
               next_state = rec_host_pkg::ST_POLL_CA;
            end else begin
               next_state = rec_host_pkg::ST_WR_HWC;
            end
         end
         rec_host_pkg::ST_WR_HWC: begin
            next_state = stopping ? rec_host_pkg::ST_POLL_CA : rec_host_pkg::ST_WAIT_FRM;
         end
         rec_host_pkg::ST_WAIT_FRM: begin
            if (stop_now) begin
               next_state = rec_host_pkg::ST_WR_HWC;
            end else if (frame_ready) begin
               next_state = rec_host_pkg::ST_RD_BUF;
            end
         end
         rec_host_pkg::ST_RD_BUF: begin
            next_state = rec_host_pkg::ST_GET_BUF;
         end
         rec_host_pkg::ST_GET_BUF: begin
            next_state = burst_last ? rec_host_pkg::ST_REARM : rec_host_pkg::ST_RD_BUF;
         end
         rec_host_pkg::ST_REARM: begin
            // The ready level must drop before the next burst, or one burst is read twice.
            if (!frame_ready) begin
               next_state = rec_host_pkg::ST_WAIT_FRM;
            end
         end
         default: begin
            next_state = rec_host_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state <= rec_host_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Session control.
   // ************************************************************
   // A sync or start response that does not echo its command is only flagged; the sequence goes on,
   // so software can still stop the session cleanly.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         linear <= 1'b0;
         started <= 1'b0;
         error <= 1'b0;
         response <= 16'h0000;
      end else begin
         if (idle && start_cmd) begin
            linear <= i_sw_wdata[rec_host_pkg::CTL_LINEAR];
            started <= 1'b0;
            error <= 1'b0;
         end
         if (state == rec_host_pkg::ST_GET_RESP) begin
            response <= i_dev_data;
            if (!stopping) begin
               started <= 1'b1;
               if (i_dev_data != cmd_word) begin
                  error <= 1'b1;
               end
            end
         end
      end
   end

   // A stop written in the cycle in which an earlier one is taken wins over the clear;
   // it then stays pending until idle, while the stop already under way goes on.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         stop_req <= 1'b0;
      end else if (stop_cmd && !idle) begin
         stop_req <= 1'b1;
      end else if (stop_take || idle) begin
         stop_req <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         stopping <= 1'b0;
      end else if (idle && start_cmd) begin
         stopping <= 1'b0;
      end else if (stop_take) begin
         stopping <= 1'b1;
      end
   end

   // ************************************************************
   // Frame capture.
   // ************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         frame_word <= 8'd0;
         burst_word <= 5'd0;
      end else begin
         if (idle && start_cmd) begin
            frame_word <= 8'd0;
            burst_word <= 5'd0;
         end
         if (state == rec_host_pkg::ST_GET_BUF) begin
            burst_word <= burst_last ? 5'd0 : burst_word + 5'd1;
            frame_word <= frame_last ? 8'd0 : frame_word + 8'd1;
         end
      end
   end

   // Only whole frames are counted, so software sees progress in frame steps.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         frames <= 16'h0000;
      end else if (idle && start_cmd) begin
         frames <= 16'h0000;
      end else if (frame_done) begin
         frames <= frames + 16'h0001;
      end
   end

   // The acknowledge is a level held over the whole burst, not a pulse per word.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         dma_ack <= 1'b0;
      end else if (ack_on) begin
         dma_ack <= 1'b1;
      end else if (burst_done) begin
         dma_ack <= 1'b0;
      end
   end

   // One frame is kept; software must drain it before the first word of the next one is written.
   always_ff @(posedge i_clk_sys) begin
      if (state == rec_host_pkg::ST_GET_BUF) begin
         frame_mem[frame_word] <= i_dev_data;
      end
   end

   // ************************************************************
   // Device port drive.
   // ************************************************************
   // Address and write data are registered from the next state, so they switch together with the state
   // and stand exactly in the strobe cycle.
   always_comb begin
      case (next_state)
         rec_host_pkg::ST_POLL_CA, rec_host_pkg::ST_POLL_RP: addr = rec_host_pkg::DEV_HW_REG;
         rec_host_pkg::ST_WR_HWC: addr = rec_host_pkg::DEV_HW_REG;
         rec_host_pkg::ST_RD_BUF: addr = rec_host_pkg::DEV_RX_BUF;
         default: addr = rec_host_pkg::DEV_SW_REG;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         dout <= 16'h0000;
         o_dev_addr <= rec_host_pkg::DEV_SW_REG;
      end else begin
         dout <= (next_state == rec_host_pkg::ST_WR_HWC) ? hwc_word : cmd_word;
         o_dev_addr <= addr;
      end
   end

   wire dev_write = (state == rec_host_pkg::ST_WR_CMD) || (state == rec_host_pkg::ST_WR_HWC);
   wire dev_read = (state == rec_host_pkg::ST_POLL_CA) || (state == rec_host_pkg::ST_POLL_RP) ||
                   (state == rec_host_pkg::ST_RD_RESP) || (state == rec_host_pkg::ST_RD_BUF);
   assign o_dev_data = dout;
   assign o_dev_data_oe = dev_write;
   assign o_dev_wr_n = !dev_write;
   assign o_dev_rd_n = !dev_read;
   assign o_dev_cs_n = !(dev_write || dev_read);
   assign o_rx_dma_ack_n = !dma_ack;

   // ************************************************************
   // Software registers.
   // ************************************************************
   wire [31:0] status_word = {27'h0000000, stop_req, linear, error, started && !stopping, !idle};
   always_comb begin
      case (i_sw_addr)
         rec_host_pkg::SW_STATUS: rdata = status_word;
         rec_host_pkg::SW_RESPONSE: rdata = {16'h0000, response};
         rec_host_pkg::SW_FRAMES: rdata = {16'h0000, frames};
         rec_host_pkg::SW_INDEX: rdata = {24'h000000, rd_index};
         rec_host_pkg::SW_DATA: rdata = {16'h0000, frame_mem[rd_index]};
         rec_host_pkg::SW_CONTROL: rdata = {30'h00000000, linear, 1'b0};
         default: rdata = 32'h00000000;
      endcase
   end

   // Read data stand for one cycle and are zero otherwise, so a stale word never looks like an answer.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_sw_rdata <= 32'h00000000;
      end else begin
         o_sw_rdata <= i_sw_rd ? rdata : 32'h00000000;
      end
   end

   // Reading the data word steps the index, so a frame drains with back-to-back reads.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         rd_index <= 8'd0;
      end else if (sw_idx_wr) begin
         rd_index <= i_sw_wdata[7:0];
      end else if (sw_data_rd) begin
         rd_index <= rd_index + 8'd1;
      end
   end
endmodule
`default_nettype wire

/* sim/rec_host_properties.sv */
// Checker for the device-side command and transfer order of rec_host.
// Assumes only the ports of rec_host; bound to every instance.
`default_nettype none
module rec_host_properties (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [1:0] o_dev_addr,
   input wire logic o_dev_cs_n,
   input wire logic o_dev_rd_n,
   input wire logic o_dev_wr_n,
   input wire logic [15:0] o_dev_data,
   input wire logic o_dev_data_oe,
   input wire logic [15:0] i_dev_data,
   input wire logic i_dev_irq,
   input wire logic i_rx_dma_request,
   input wire logic o_rx_dma_ack_n
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   wire rd = !o_dev_cs_n && !o_dev_rd_n;
   wire wr = !o_dev_cs_n && !o_dev_wr_n;
   wire cmd = wr && o_dev_addr == 2'h0;
   wire brd = rd && o_dev_addr == 2'h2;
   logic irq_q;
   logic stopped;
   logic [4:0] icnt;
   logic [4:0] acnt;
   logic [15:0] hwc;
   logic [15:0] last;
   // Reads are counted per interrupt and per acknowledge so a short burst is seen at its end.
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         irq_q <= 1'b0;
         stopped <= 1'b1;
         icnt <= 5'h0;
         acnt <= 5'h0;
         hwc <= 16'h0;
         last <= 16'h0;
      end else begin
         irq_q <= i_dev_irq;
         icnt <= (i_dev_irq && !irq_q) ? 5'h0 : icnt + 5'(brd && o_rx_dma_ack_n);
         acnt <= o_rx_dma_ack_n ? 5'h0 : acnt + 5'(brd);
         if (wr && o_dev_addr == 2'h1) hwc <= o_dev_data;
         if (cmd) last <= o_dev_data;
         if (cmd) stopped <= o_dev_data[15:12] != 4'h1;
      end
   end
   property p_cmd_ca; cmd |-> $past(rd && o_dev_addr == 2'h1, 2) && $past(i_dev_data[0]); endproperty
   a_cmd_ca: assert property (p_cmd_ca) else $error("command without ready poll");
   property p_resp_rp; rd && o_dev_addr == 2'h0 |-> $past(rd && o_dev_addr == 2'h1, 2) && $past(i_dev_data[1]); endproperty
   a_resp_rp: assert property (p_resp_rp) else $error("response read without pending");
   property p_start; cmd && o_dev_data[15:12] == 4'h1 |-> last == 16'h5102; endproperty
   a_start: assert property (p_start) else $error("record start without poll sync");
   property p_hwc; wr && o_dev_addr == 2'h1 |-> o_dev_data inside {16'h0401, 16'h0050, 16'h0000}; endproperty
   a_hwc: assert property (p_hwc) else $error("bad hardware control word");
   property p_burst; $rose(o_rx_dma_ack_n) |-> acnt == 5'd16; endproperty
   a_burst: assert property (p_burst) else $error("dma burst not 16 words");
   property p_cframe; $fell(i_dev_irq) |-> icnt inside {5'd0, 5'd10}; endproperty
   a_cframe: assert property (p_cframe) else $error("interrupt frame not 10 words");
   property p_stop; cmd && o_dev_data == 16'h5120 |-> hwc == 16'h0; endproperty
   a_stop: assert property (p_stop) else $error("stop before requests disabled");
   property p_nobuf; brd |-> !stopped; endproperty
   a_nobuf: assert property (p_nobuf) else $error("buffer read outside record");
   property p_ack; $fell(o_rx_dma_ack_n) |-> $past(i_rx_dma_request); endproperty
   a_ack: assert property (p_ack) else $error("acknowledge without dma request");
   property p_oe; o_dev_data_oe == wr; endproperty
   a_oe: assert property (p_oe) else $error("data enable not matching write strobe");
endmodule
bind rec_host rec_host_properties u_rec_host_properties (.i_clk_sys, .i_sys_rst, .o_dev_addr, .o_dev_cs_n,
   .o_dev_rd_n, .o_dev_wr_n, .o_dev_data, .o_dev_data_oe, .i_dev_data, .i_dev_irq, .i_rx_dma_request,
   .o_rx_dma_ack_n);
`default_nettype wire

/* sim/rec_dev_model.sv */
// Behavioural model of the co-processor host port: registers, frame source, buffer port.
// Assumes one-cycle strobes; read data stands only in the cycle after the strobe.
`default_nettype none
module rec_dev_model #(parameter int GAP = 800, parameter int SYNC = 20) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [1:0] i_addr,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [15:0] i_data,
   input wire logic i_bad,
   output logic [15:0] o_data,
   output logic o_irq,
   output logic o_req
);
   wire rd = !i_cs_n && !i_rd_n;
   wire wr = !i_cs_n && !i_wr_n;
   logic ca, rp, rec, lin, avail;
   logic [15:0] resp, hwc, pend;
   logic [7:0] widx;
   logic [4:0] bcnt;
   int dly, gap, fill;
   wire [4:0] bsz = lin ? 5'd16 : 5'd10;
   wire [7:0] fsz = lin ? 8'd240 : 8'd10;
   assign o_irq = avail && hwc[0] && hwc[10];
   assign o_req = avail && hwc[4] && hwc[6];
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         {ca, rp, rec, lin, avail} <= 5'b10000;
         {resp, hwc, pend, widx, bcnt, o_data} <= '0;
         {dly, gap, fill} <= '0;
      end else begin
         // A released bus never keeps its last value.
         o_data <= ~o_data;
         gap <= (gap == 0) ? GAP : gap - 1;
         if (rec && gap == 0 && widx == 0 && !avail) fill <= 4;
         if (fill > 1) fill <= fill - 1;
         if (fill == 1) begin fill <= 0; avail <= 1'b1; end
         if (rd && i_addr == 2'h0) begin o_data <= resp; rp <= 1'b0; end
         if (rd && i_addr == 2'h1) o_data <= {13'h0, avail, rp, ca};
         if (rd && i_addr == 2'h2) begin
            o_data <= {widx ^ 8'h5a, ~widx};
            widx <= (widx + 8'd1 == fsz) ? 8'd0 : widx + 8'd1;
            bcnt <= bcnt + 5'd1;
            if (bcnt + 5'd1 == bsz) begin
               bcnt <= 5'd0;
               avail <= 1'b0;
               if (widx + 8'd1 != fsz) fill <= 4;
            end
         end
         if (wr && i_addr == 2'h1) hwc <= i_data;
         if (dly > 1) dly <= dly - 1;
         if (dly == 1) begin
            dly <= 0; ca <= 1'b1; rp <= 1'b1;
            resp <= (i_bad && pend == 16'h5102) ? ~pend : pend;
            if (pend[15:12] == 4'h1 && pend[1:0] == 2'b11) begin
               rec <= 1'b1; lin <= pend[9:7] == 3'b101; widx <= 8'd0; bcnt <= 5'd0;
            end
            if (pend == 16'h0 || pend == 16'h5120) begin rec <= 1'b0; avail <= 1'b0; fill <= 0; end
         end
         if (wr && i_addr == 2'h0) begin
            ca <= 1'b0; pend <= i_data; dly <= (i_data[15:12] == 4'h1) ? SYNC : 3;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/rec_host_tb.sv */
// Self-checking bench for rec_host against the device model.
// Assumes the bound checker; software reads answer one cycle after the strobe.
`default_nettype none
module rec_host_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, swr = 0, srd = 0, bad = 0;
   logic [7:0] sa = 0;
   logic [31:0] swd = 0, rdat;
   wire [31:0] srdata;
   wire [1:0] da;
   wire cs_n, rd_n, wr_n, irq, req, ack_n;
   wire [15:0] dout, din;
   int errors, cmp_count;
   logic [7:0] regs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
   rec_host u_rec_host (.i_clk_sys(clk), .i_sys_rst(rst), .i_sw_addr(sa), .i_sw_wdata(swd), .i_sw_wr(swr),
      .i_sw_rd(srd), .o_sw_rdata(srdata), .o_dev_addr(da), .o_dev_cs_n(cs_n), .o_dev_rd_n(rd_n),
      .o_dev_wr_n(wr_n), .o_dev_data(dout), .o_dev_data_oe(), .i_dev_data(din), .i_dev_irq(irq),
      .i_rx_dma_request(req), .o_rx_dma_ack_n(ack_n));
   rec_dev_model u_rec_dev_model (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(da), .i_cs_n(cs_n),
      .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(dout), .i_bad(bad), .o_data(din), .o_irq(irq), .o_req(req));
   initial begin
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] ew(input logic [7:0] i);
      return {16'h0, i ^ 8'h5a, ~i};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      sa <= a; swd <= d; swr <= 1'b1;
      @(posedge clk);
      swr <= 1'b0;
   endtask
   task automatic rd32(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      sa <= a; srd <= 1'b1;
      @(posedge clk);
      srd <= 1'b0;
      #1 d = srdata;
   endtask
   // Polls one register bit until it shows the wanted level; running out of polls is a mismatch.
   task automatic wait_on(input logic [7:0] a, input int b, input logic v);
      int n;
      n = 0;
      do begin rd32(a, rdat); n++; end while (rdat[b] !== v && n < 4000);
      chk({31'h0, rdat[b]}, {31'h0, v});
   endtask
   task automatic rec_run(input logic ln, input logic b);
      logic [7:0] i;
      logic [31:0] f;
      bad <= b;
      wr32(8'h00, {30'h0, ln, 1'b1});
      wr32(8'h00, {30'h0, !ln, 1'b1});
      rd32(8'h0c, f);
      chk(f, 32'h0);
      wait_on(8'h0c, 0, 1'b1);
      rd32(8'h04, rdat);
      chk(rdat[3:1], {ln, b, 1'b1});
      rd32(8'h08, rdat);
      chk(rdat, ln ? 32'h1e83 : 32'h1c03);
      for (int k = 0; k < 5; k++) begin
         i = (k == 0) ? 8'd0 : (k == 1) ? (ln ? 8'd238 : 8'd8) : 8'($urandom % (ln ? 239 : 9));
         wr32(8'h10, {24'h0, i});
         rd32(8'h14, rdat);
         chk(rdat, ew(i));
         rd32(8'h14, rdat);
         chk(rdat, ew(i + 8'd1));
      end
      wr32(8'h00, 32'h4);
      wait_on(8'h04, 0, 1'b0);
      rd32(8'h08, rdat);
      chk(rdat, 32'h5120);
      $display("record test linear=%0d bad=%0d done", ln, b);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      finish_test();
   end
   initial begin
      void'($urandom(32'head7));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wr32(8'h00, 32'h4);
      foreach (regs[j]) begin
         rd32(regs[j], rdat);
         chk(rdat, 32'h0);
      end
      $display("reset test done");
      rec_run(1'b0, 1'b0);
      rec_run(1'b1, 1'b0);
      rec_run(1'b0, 1'b1);
      finish_test();
   end
endmodule
`default_nettype wire
